// ===== pkg/fste_pkg.sv
// Shared constants, types and operand classifier for the status, tag and exception unit.
package fste_pkg;

    // ************************************************************
    // Status word layout
    // ************************************************************
    localparam int SW_IE  = 0;
    localparam int SW_DE  = 1;
    localparam int SW_ZE  = 2;
    localparam int SW_OE  = 3;
    localparam int SW_UE  = 4;
    localparam int SW_PE  = 5;
    localparam int SW_SF  = 6;
    localparam int SW_ES  = 7;
    localparam int SW_C0  = 8;
    localparam int SW_C1  = 9;
    localparam int SW_C2  = 10;
    localparam int SW_C3  = 14;
    localparam logic [15:0] SW_RESET = 16'h0000;

    // ************************************************************
    // Control word layout
    // ************************************************************
    localparam int CW_IM    = 0;
    localparam int CW_DM    = 1;
    localparam int CW_OM    = 3;
    localparam int CW_UM    = 4;
    localparam int CW_PC_LO = 8;
    localparam int CW_RC_LO = 10;
    localparam int CW_IC    = 12;
    localparam logic [15:0] CW_RESET = 16'h037F;
    localparam logic [5:0]  EXC_MASK_ALL = 6'h3F;

    // Rounding control and precision encodings.
    localparam logic [1:0] RC_NEAREST = 2'h0;
    localparam logic [1:0] RC_DOWN    = 2'h1;
    localparam logic [1:0] RC_UP      = 2'h2;
    localparam logic [1:0] RC_CHOP    = 2'h3;
    localparam logic [1:0] PREC_EXT   = 2'h3;

    // ************************************************************
    // Tag codes and extended-format fields
    // ************************************************************
    localparam logic [1:0] TAG_VALID   = 2'h0;
    localparam logic [1:0] TAG_ZERO    = 2'h1;
    localparam logic [1:0] TAG_SPECIAL = 2'h2;
    localparam logic [1:0] TAG_EMPTY   = 2'h3;
    localparam int NUM_REGS = 8;
    localparam int EXP_MSB  = 78;
    localparam int EXP_LSB  = 64;
    localparam int JBIT     = 63;
    localparam int QBIT     = 62;
    localparam logic [14:0] EXP_ZERO = 15'h0000;
    localparam logic [14:0] EXP_MAX  = 15'h7FFF;

    typedef enum logic [2:0] {
        CL_VALID = 3'h0, CL_ZERO = 3'h1, CL_INF = 3'h2, CL_DENORM = 3'h3,
        CL_QNAN  = 3'h4, CL_SNAN = 3'h5, CL_UNSUP = 3'h6
    } fste_class_t;

    typedef enum logic [3:0] {
        OP_MOVE    = 4'h0, OP_ARITH   = 4'h1, OP_COMPARE  = 4'h2, OP_INT_STORE = 4'h3,
        OP_DEC_STO = 4'h4, OP_TRANSC  = 4'h5, OP_EXTRACT  = 4'h6, OP_PREM     = 4'h7,
        OP_PREM1   = 4'h8, OP_PTAN    = 4'h9
    } fste_kind_t;

    typedef enum logic [2:0] {
        EXC_NONE = 3'h0, EXC_INV = 3'h1, EXC_DEN = 3'h2, EXC_ZDIV = 3'h3,
        EXC_OVF  = 3'h4, EXC_UNF = 3'h5, EXC_PREC = 3'h6
    } fste_exc_t;

    typedef enum logic [1:0] {
        OVF_NONE = 2'h0, OVF_INF = 2'h1, OVF_MAX_FINITE = 2'h2
    } fste_ovf_t;

    // One finished operation as reported by the datapath.
    typedef struct packed {
        fste_kind_t kind;
        logic [2:0] src_a;
        logic [2:0] src_b;
        logic       two_src;
        logic       stack_dest;
        logic       uses_pc;
        logic       incomplete;
        logic       cc_wr;
        logic [3:0] cc_val;
        logic       zero_div;
        logic       res_overflow;
        logic       res_tiny;
        logic       res_inexact;
        logic       res_sign;
        logic       stack_ovf;
        logic       stack_unf;
    } fste_op_t;

    // Result handling returned to the datapath.
    typedef struct packed {
        logic        quiet_nan;
        logic        indefinite;
        logic        normalize;
        logic        exp_adjust;
        fste_ovf_t   ovf_sel;
        logic [1:0]  round_prec;
        fste_exc_t   first_exc;
    } fste_res_t;

    // Classifies an extended-precision value from its bits alone.
    function automatic fste_class_t fste_classify(input logic [79:0] v);
        logic [14:0] e;
        e = v[EXP_MSB:EXP_LSB];
        if (e == EXP_ZERO) begin
            fste_classify = (v[JBIT:0] == '0) ? CL_ZERO :
                            (v[JBIT] ? CL_UNSUP : CL_DENORM);
        end else if (!v[JBIT]) begin
            fste_classify = CL_UNSUP;
        end else if (e == EXP_MAX) begin
            fste_classify = (v[QBIT-1:0] == '0 && !v[QBIT]) ? CL_INF :
                            (v[QBIT] ? CL_QNAN : CL_SNAN);
        end else begin
            fste_classify = CL_VALID;
        end
    endfunction

    // Maps a class onto the two-bit tag code.
    function automatic logic [1:0] fste_tag_of(input fste_class_t c);
        case (c)
            CL_VALID: fste_tag_of = TAG_VALID;
            CL_ZERO:  fste_tag_of = TAG_ZERO;
            default:  fste_tag_of = TAG_SPECIAL;
        endcase
    endfunction

endpackage

// ===== logic/fste_unit.sv
// Status word, tag word and exception signalling for the floating-point stack unit.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Reset and the initialise instruction clear the four condition-code flags.
// - An incomplete partial remainder clears condition codes zero, one and three.
// - Condition code two flags an incomplete partial tangent.
// - Stack overflow or underflow sets invalid and stack fault; code one tells which.
// - Infinity-control bit is kept readable and writable; arithmetic stays affine.
// - Loaded tags reduce to empty (11) or non-empty (00, 01, 10).
// - Operands are classified from register contents, never from a loaded tag.
// - Saving the tag word recomputes tags of non-empty registers from contents.
// - Unsupported formats, pseudo-zero and unnormal included, are tagged 10.
// - Only quiet NaNs are produced; invalid for signalling NaNs and some quiet ones.
// - Pseudo and unnormal operands are never produced and raise invalid in every operation except a move.
// - Masked denormal operands are normalised instead of giving denormal results.
// - Transcendental and extract instructions raise the denormal exception too.
// - Masked overflow rounding toward zero gives the largest finite magnitude.
// - Unmasked overflow sets precision; stack results round per precision control.
// - Masked underflow is flagged only when tiny and inexact.
// - Unmasked underflow to stack adjusts exponent, then rounds to set precision.
// - Denormal exception priority is the same whether masked or not.
module fste_unit
    import fste_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 reset_n_i,
    input  wire logic                 init_i,
    input  wire logic                 cw_wr_i,
    input  wire logic [15:0]          cw_data_i,
    input  wire logic                 sw_wr_i,
    input  wire logic [15:0]          sw_data_i,
    input  wire logic                 tag_load_i,
    input  wire logic [15:0]          tag_data_i,
    input  wire logic                 tag_save_i,
    input  wire logic                 reg_load_i,
    input  wire logic [2:0]           reg_load_idx_i,
    input  wire logic                 reg_free_i,
    input  wire logic [2:0]           reg_free_idx_i,
    input  wire logic [7:0][79:0]     reg_file_i,
    input  wire logic                 op_done_i,
    input  wire fste_op_t             op_i,
    output logic [15:0]               status_word_o,
    output logic [15:0]               control_word_o,
    output logic [15:0]               tag_word_o,
    output logic [7:0]                tag_empty_o,
    output fste_class_t               class_a_o,
    output fste_class_t               class_b_o,
    output fste_res_t                 res_ctl_o
);

    // ************************************************************
    // Operand classification
    // ************************************************************

    fste_class_t cls_a;
    fste_class_t cls_b;
    logic        any_snan;
    logic        any_qnan;
    logic        any_unsup;
    logic        any_denorm;
    logic        qnan_traps;
    logic        arith_kind;

    // Classes come straight from the register bits, whatever tag was loaded.
    always_comb begin
        cls_a = fste_classify(reg_file_i[op_i.src_a]);
        cls_b = op_i.two_src ? fste_classify(reg_file_i[op_i.src_b]) : CL_VALID;
    end

    // Operand summaries used by the flag logic.
    always_comb begin
        any_snan   = (cls_a == CL_SNAN)   || (cls_b == CL_SNAN);
        any_qnan   = (cls_a == CL_QNAN)   || (cls_b == CL_QNAN);
        any_unsup  = (cls_a == CL_UNSUP)  || (cls_b == CL_UNSUP);
        any_denorm = (cls_a == CL_DENORM) || (cls_b == CL_DENORM);
        qnan_traps = (op_i.kind == OP_COMPARE) || (op_i.kind == OP_INT_STORE) ||
                     (op_i.kind == OP_DEC_STO);
        arith_kind = (op_i.kind != OP_MOVE);
    end

    // ************************************************************
    // New exception conditions of the finishing operation
    // ************************************************************

    logic       ex_inv;
    logic       ex_den;
    logic       ex_ze;
    logic       ex_oe;
    logic       ex_ue;
    logic       ex_pe;
    logic       stack_fault;
    logic [5:0] cw_mask;
    logic [1:0] cw_rc;

    assign cw_mask = control_word_o[5:0];
    assign cw_rc   = control_word_o[CW_RC_LO+1:CW_RC_LO];

    // Invalid, denormal, overflow, underflow and precision conditions.
    always_comb begin
        stack_fault = op_i.stack_ovf || op_i.stack_unf;
        ex_inv = any_snan
               || (any_qnan && qnan_traps)
               || (any_unsup && arith_kind)
               || stack_fault;
        ex_den = any_denorm;
        ex_ze  = op_i.zero_div;
        ex_oe  = op_i.res_overflow;
        ex_ue  = op_i.res_tiny &&
                 (!cw_mask[CW_UM] || op_i.res_inexact);
        ex_pe  = op_i.res_inexact ||
                 (op_i.res_overflow && !cw_mask[CW_OM]);
    end

    // ************************************************************
    // Status word
    // ************************************************************

    logic [15:0] next_status;

    // Software write first, then new events ORed on top so a set wins a clear.
    always_comb begin
        next_status = status_word_o;
        if (sw_wr_i) begin
            next_status = sw_data_i;
        end
        if (op_done_i) begin
            next_status[SW_IE] = next_status[SW_IE] | ex_inv;
            next_status[SW_DE] = next_status[SW_DE] | ex_den;
            next_status[SW_ZE] = next_status[SW_ZE] | ex_ze;
            next_status[SW_OE] = next_status[SW_OE] | ex_oe;
            next_status[SW_UE] = next_status[SW_UE] | ex_ue;
            next_status[SW_PE] = next_status[SW_PE] | ex_pe;
            if (op_i.cc_wr) begin
                next_status[SW_C0] = op_i.cc_val[0];
                next_status[SW_C1] = op_i.cc_val[1];
                next_status[SW_C2] = op_i.cc_val[2];
                next_status[SW_C3] = op_i.cc_val[3];
            end
            if (op_i.kind == OP_PREM || op_i.kind == OP_PREM1) begin
                next_status[SW_C2] = op_i.incomplete;
                if (op_i.incomplete) begin
                    next_status[SW_C0] = 1'b0;
                    next_status[SW_C1] = 1'b0;
                    next_status[SW_C3] = 1'b0;
                end
            end
            if (op_i.kind == OP_PTAN) begin
                next_status[SW_C2] = op_i.incomplete;
            end
            if (stack_fault) begin
                next_status[SW_SF] = 1'b1;
                next_status[SW_C1] = op_i.stack_ovf;
            end
        end
        if (init_i) begin
            next_status = SW_RESET;
        end
        next_status[SW_ES] = |(next_status[SW_PE:SW_IE] & ~control_word_o[5:0]);
    end

    // Status register.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_word_o <= SW_RESET;
        end else begin
            status_word_o <= next_status;
        end
    end

    // ************************************************************
    // Control word
    // ************************************************************

    // Bit 12 is stored and read back but no logic here looks at it.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            control_word_o <= CW_RESET;
        end else if (init_i) begin
            control_word_o <= CW_RESET;
        end else if (cw_wr_i) begin
            control_word_o <= cw_data_i;
        end
    end

    // ************************************************************
    // Tag word
    // ************************************************************

    logic [7:0]  next_empty;
    logic [15:0] saved_tags;

    // Per register: empty bit update and tag recomputed from contents.
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_tag
        always_comb begin
            next_empty[i] = tag_empty_o[i];
            if (reg_free_i && reg_free_idx_i == 3'(i)) begin
                next_empty[i] = 1'b1;
            end
            if (reg_load_i && reg_load_idx_i == 3'(i)) begin
                next_empty[i] = 1'b0;
            end
            if (tag_load_i) begin
                next_empty[i] = (tag_data_i[2*i+1:2*i] == TAG_EMPTY);
            end
            if (init_i) begin
                next_empty[i] = 1'b1;
            end
        end
        assign saved_tags[2*i+1:2*i] = tag_empty_o[i] ? TAG_EMPTY :
            fste_tag_of(fste_classify(reg_file_i[i]));
    end

    // Empty bits; only the empty or non-empty fact of a loaded tag is kept.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tag_empty_o <= '1;
        end else begin
            tag_empty_o <= next_empty;
        end
    end

    // Tag word presented for a save, captured from fresh classification.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tag_word_o <= '1;
        end else if (tag_save_i) begin
            tag_word_o <= saved_tags;
        end
    end

    // ************************************************************
    // Result control
    // ************************************************************

    fste_res_t next_res;

    // Priority of the first exception is fixed and ignores the masks.
    always_comb begin
        next_res = '0;
        next_res.first_exc = ex_inv ? EXC_INV :
                             ex_den ? EXC_DEN :
                             ex_ze  ? EXC_ZDIV :
                             ex_oe  ? EXC_OVF :
                             ex_ue  ? EXC_UNF :
                             ex_pe  ? EXC_PREC : EXC_NONE;
        next_res.quiet_nan  = any_snan || any_qnan;
        next_res.indefinite = ex_inv && cw_mask[CW_IM] && !(any_snan || any_qnan);
        next_res.normalize  = ex_den && cw_mask[CW_DM];
        next_res.round_prec = op_i.uses_pc ? control_word_o[CW_PC_LO+1:CW_PC_LO] :
                              PREC_EXT;
        next_res.exp_adjust = op_i.stack_dest &&
                              ((ex_oe && !cw_mask[CW_OM]) ||
                               (op_i.res_tiny && !cw_mask[CW_UM]));
        if (ex_oe && cw_mask[CW_OM]) begin
            case (cw_rc)
                RC_CHOP: next_res.ovf_sel = OVF_MAX_FINITE;
                RC_DOWN: next_res.ovf_sel = op_i.res_sign ? OVF_INF : OVF_MAX_FINITE;
                RC_UP:   next_res.ovf_sel = op_i.res_sign ? OVF_MAX_FINITE : OVF_INF;
                default: next_res.ovf_sel = OVF_INF;
            endcase
        end
    end

    // Result control and operand classes registered with each operation.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            res_ctl_o <= '0;
            class_a_o <= CL_VALID;
            class_b_o <= CL_VALID;
        end else if (op_done_i) begin
            res_ctl_o <= next_res;
            class_a_o <= cls_a;
            class_b_o <= cls_b;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************

    AST_INIT_CC: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        init_i |=> (status_word_o[SW_C0] == 1'b0 && status_word_o[SW_C1] == 1'b0 &&
                    status_word_o[SW_C2] == 1'b0 && status_word_o[SW_C3] == 1'b0))
        else $error("Condition codes not cleared after init.");

    AST_PREM_INC: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (op_done_i && !init_i && op_i.incomplete && !stack_fault &&
         (op_i.kind == OP_PREM || op_i.kind == OP_PREM1))
        |=> (status_word_o[SW_C0] == 1'b0 && status_word_o[SW_C1] == 1'b0 &&
             status_word_o[SW_C3] == 1'b0 && status_word_o[SW_C2] == 1'b1))
        else $error("Incomplete remainder left wrong condition codes.");

    AST_PTAN_C2: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (op_done_i && !init_i && op_i.kind == OP_PTAN)
        |=> (status_word_o[SW_C2] == $past(op_i.incomplete)))
        else $error("Tangent incomplete flag wrong.");

    AST_STACK_FAULT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (op_done_i && !init_i && stack_fault)
        |=> (status_word_o[SW_IE] && status_word_o[SW_SF] &&
             status_word_o[SW_C1] == $past(op_i.stack_ovf)))
        else $error("Stack fault not flagged correctly.");

    AST_TAG_LOAD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (tag_load_i && !init_i) |=> (tag_empty_o[0] == ($past(tag_data_i[1:0]) == TAG_EMPTY)))
        else $error("Loaded tag not reduced to empty or non-empty.");

    AST_TAG_SAVE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (tag_save_i && !tag_empty_o[4] && fste_classify(reg_file_i[4]) == CL_UNSUP)
        |=> (tag_word_o[9:8] == TAG_SPECIAL))
        else $error("Unsupported format not tagged special.");

    AST_SNAN_INV: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (op_done_i && !init_i && any_snan) |=> (status_word_o[SW_IE] && res_ctl_o.quiet_nan))
        else $error("Signalling NaN did not raise invalid.");

    AST_OVF_CHOP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (op_done_i && op_i.res_overflow && cw_mask[CW_OM] && cw_rc == RC_CHOP)
        |=> (res_ctl_o.ovf_sel == OVF_MAX_FINITE))
        else $error("Chopped masked overflow did not give largest finite.");

    AST_OVF_PE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (op_done_i && !init_i && op_i.res_overflow && !cw_mask[CW_OM])
        |=> status_word_o[SW_PE])
        else $error("Unmasked overflow did not set precision flag.");

    AST_UNF_MASK: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (op_done_i && !sw_wr_i && !status_word_o[SW_UE] && cw_mask[CW_UM] &&
         op_i.res_tiny && !op_i.res_inexact) |=> !status_word_o[SW_UE])
        else $error("Masked exact tiny result raised underflow.");

    AST_STICKY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (status_word_o[SW_IE] && !sw_wr_i && !init_i) |=> status_word_o[SW_IE])
        else $error("Invalid flag dropped without a clear.");

endmodule // fste_unit

`default_nettype wire

// ===== test/fste_unit_tb.sv
// Self-checking testbench for the status, tag and exception unit.
`timescale 1ns/1ns
`default_nettype none
module fste_unit_tb
    import fste_pkg::*;
;
    logic             clk_i = 1'b0;
    logic             reset_n_i = 1'b0;
    logic [6:0]       stb = 7'h00;
    logic             op_done_i = 1'b0;
    logic [15:0]      dat = 16'h0000;
    logic [2:0]       idx = 3'h0;
    logic [7:0][79:0] rf;
    fste_op_t         op_i = '0;
    logic [15:0]      sw_o, cw_o, tw_o;
    logic [7:0]       te_o;
    fste_class_t      ca_o, cb_o;
    fste_res_t        rc_o;
    int               err_total = 0;
    int               num_checks = 0;
    int               cyc = 0;

    // Strobe bits: 0 init, 1 control, 2 status, 3 tag load, 4 tag save, 5 free, 6 load.
    fste_unit dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .init_i(stb[0]), .cw_wr_i(stb[1]),
        .cw_data_i(dat), .sw_wr_i(stb[2]), .sw_data_i(dat), .tag_load_i(stb[3]),
        .tag_data_i(dat), .tag_save_i(stb[4]), .reg_load_i(stb[6]), .reg_load_idx_i(idx),
        .reg_free_i(stb[5]), .reg_free_idx_i(idx), .reg_file_i(rf), .op_done_i(op_done_i),
        .op_i(op_i), .status_word_o(sw_o), .control_word_o(cw_o), .tag_word_o(tw_o),
        .tag_empty_o(te_o), .class_a_o(ca_o), .class_b_o(cb_o), .res_ctl_o(rc_o));

    // The clock toggles every half period of 10 ns.
    always #10 clk_i = ~clk_i;

    // A hang is cut short after a generous cycle count.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            end_of_test();
        end
    end

    // ************************************************************
    // Access tasks
    // ************************************************************
    // Compares a seen value with the expected one and counts both.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Pulses one strobe for a cycle with its data, then waits for the answer.
    task automatic strobe(input int s, input logic [15:0] d);
        @(posedge clk_i);
        dat <= d;
        idx <= d[2:0];
        stb <= 7'(1 << s);
        @(posedge clk_i);
        stb <= 7'h00;
        #1;
    endtask

    // Reports one finished operation; f packs the event bits of the operation.
    task automatic op(input fste_kind_t k, input logic [2:0] a, input logic [5:0] f);
        fste_op_t o;
        o = '0;
        o.kind = k;
        o.src_a = a;
        o.src_b = a;
        o.two_src = (k == OP_COMPARE);
        o.stack_dest = 1'b1;
        o.uses_pc = 1'b1;
        {o.stack_ovf, o.stack_unf, o.res_overflow, o.res_tiny, o.res_inexact, o.incomplete} = f;
        @(posedge clk_i);
        op_i <= o;
        op_done_i <= 1'b1;
        @(posedge clk_i);
        op_done_i <= 1'b0;
        #1;
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    // Registers hold QNaN, denormal, pseudo-zero, unnormal, SNaN, zero, -, valid (7 down to 0).
    initial begin
        rf = {80'h7FFF_C000_0000_0000_0000, 80'h0000_0000_0000_0000_0001,
              80'h0000_8000_0000_0000_0000, 80'h3FFF_4000_0000_0000_0000,
              80'h7FFF_A000_0000_0000_0000, 80'h0, 80'h0, 80'h3FFF_8000_0000_0000_0000};
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        #1;
        chk(sw_o, SW_RESET);
        chk(tw_o, 16'hFFFF);
        strobe(2, 16'h4700);
        chk(sw_o, 16'h4700);
        strobe(1, 16'h1F7F);
        chk(cw_o, 16'h1F7F);
        strobe(0, 16'h0000);
        chk(sw_o, 16'h0000);
        chk(cw_o, CW_RESET);
        $display("test reset done");
        strobe(3, 16'h04CE);
        chk({8'h00, te_o}, 16'h000A);
        strobe(4, 16'h0000);
        chk(tw_o, 16'hAADC);
        strobe(5, 16'h0002);
        strobe(6, 16'h0001);
        chk({8'h00, te_o}, 16'h000C);
        $display("test tags done");
        op(OP_MOVE, 3'h0, 6'h20);
        chk(sw_o, 16'h0241);
        op(OP_MOVE, 3'h0, 6'h10);
        chk(sw_o, 16'h0041);
        strobe(2, 16'h4300);
        op(OP_PREM, 3'h0, 6'h01);
        chk(sw_o, 16'h0400);
        strobe(2, 16'h4300);
        op(OP_PREM1, 3'h0, 6'h01);
        chk(sw_o, 16'h0400);
        strobe(2, 16'h0000);
        op(OP_PTAN, 3'h0, 6'h01);
        chk(sw_o, 16'h0400);
        $display("test condition codes done");
        strobe(2, 16'h0000);
        op(OP_ARITH, 3'h7, 6'h00);
        chk(sw_o, 16'h0000);
        chk(16'(ca_o), 16'(CL_QNAN));
        chk(16'(cb_o), 16'(CL_VALID));
        chk(16'(rc_o.quiet_nan), 16'h0001);
        op(OP_COMPARE, 3'h7, 6'h00);
        chk(sw_o, 16'h0001);
        chk(16'(cb_o), 16'(CL_QNAN));
        strobe(2, 16'h0000);
        op(OP_ARITH, 3'h3, 6'h00);
        chk(sw_o, 16'h0001);
        chk(16'(ca_o), 16'(CL_SNAN));
        strobe(2, 16'h0000);
        op(OP_ARITH, 3'h4, 6'h00);
        chk(sw_o, 16'h0001);
        strobe(2, 16'h0000);
        op(OP_TRANSC, 3'h6, 6'h00);
        chk(sw_o, 16'h0002);
        chk(16'(rc_o.normalize), 16'h0001);
        chk(16'(rc_o.first_exc), 16'(EXC_DEN));
        strobe(2, 16'h0000);
        op(OP_EXTRACT, 3'h6, 6'h00);
        chk(sw_o, 16'h0002);
        $display("test operands done");
        strobe(2, 16'h0000);
        strobe(1, 16'h0F7F);
        op(OP_ARITH, 3'h0, 6'h0A);
        chk(16'(rc_o.ovf_sel), 16'(OVF_MAX_FINITE));
        chk(sw_o, 16'h0028);
        strobe(2, 16'h0000);
        strobe(1, 16'h037F);
        op(OP_ARITH, 3'h0, 6'h04);
        chk(sw_o, 16'h0000);
        op(OP_ARITH, 3'h0, 6'h06);
        chk(sw_o, 16'h0030);
        strobe(1, 16'h036F);
        op(OP_ARITH, 3'h0, 6'h04);
        chk({13'h0000, rc_o.exp_adjust, rc_o.round_prec}, 16'h0007);
        strobe(1, 16'h0277);
        op(OP_ARITH, 3'h0, 6'h0A);
        chk({15'h0000, sw_o[SW_PE]}, 16'h0001);
        chk(16'(rc_o.round_prec), 16'h0002);
        $display("test numeric exceptions done");
        end_of_test();
    end
endmodule // fste_unit_tb
`default_nettype wire
